// ==== hdl/swk_fd_trim_pkg.sv ====
package swk_fd_trim_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  localparam logic [6:0] ADDR_PAYLOAD_BYTE_ZERO = 7'h33;
  localparam logic [6:0] ADDR_FD_TOLERANT_CONTROL = 7'h34;
  localparam logic [6:0] ADDR_OSCILLATOR_TRIM_LOW = 7'h38;
  localparam logic [6:0] ADDR_WAKE_OPTIONS_TRIM_HIGH = 7'h39;
  localparam logic [6:0] ADDR_OSCILLATOR_CALIBRATION_HIGH = 7'h3a;

  localparam int unsigned FD_ENABLE_BIT = 0;
  localparam int unsigned DOMINANT_FILTER_TIME_LSB = 1;
  localparam int unsigned DOMINANT_FILTER_TIME_MSB = 3;
  localparam int unsigned FD_BYPASS_BIT = 4;
  localparam int unsigned FD_ERRDIS_BIT = 5;
  localparam int unsigned OPT_TRIM_LSB = 0;
  localparam int unsigned OPT_TRIM_MSB = 4;
  localparam int unsigned OPT_RXSEL_BIT = 7;

  localparam logic [7:0] FD_CONTROL_RESET = 8'h00;
  localparam logic [7:0] PAYLOAD_RESET = 8'h00;
  localparam logic [7:0] CAL_HIGH_RESET = 8'h00;
  localparam logic [7:0] TRIM_LOW_RESET = 8'h00;
  localparam logic [4:0] TRIM_HIGH_RESET = 5'h00;
  localparam logic WAKE_RX_SELECT_RESET = 1'b0;

  localparam logic [1:0] TRIM_UNLOCK_CODE = 2'h3;

  // Dominant filter times in ns for codes 0..7
  localparam int unsigned FILTER_STEP_NS = 50;
  localparam int unsigned FILTER_LONG_NS = 775;
  localparam logic [2:0] FILTER_LONG_CODE = 3'h7;

  typedef struct packed {
    logic write;
    logic read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic error_counter_disable;
    logic receive_analog_filter_bypass;
    logic [2:0] dominant_filter_time;
    logic fd_tolerant_enable;
  } fd_control_t;

  typedef struct packed {
    logic [4:0] coarse;
    logic [2:0] tempco;
    logic [4:0] fine;
  } trim_word_t;

endpackage : swk_fd_trim_pkg

// ==== hdl/selective_wake_fd_trim_regs.sv ====
`timescale 1ns/1ps
module selective_wake_fd_trim_regs
  import swk_fd_trim_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire reg_req_t req_i,
  input wire logic [1:0] trim_enable_i,
  input wire logic silence_timeout_i,
  input wire logic [7:0] calibration_high_i,
  output logic [7:0] rd_data_o,
  output fd_control_t fd_control_o,
  output logic error_counter_active_o,
  output logic analog_filter_in_path_o,
  output logic [5:0] dominant_filter_cycles_o,
  output trim_word_t trim_word_o,
  output logic wake_receiver_select_o,
  output logic [7:0] payload_byte_zero_o
);

  // Each filter time rounds up to whole clock cycles
  function automatic logic [5:0] filter_cycles(input logic [2:0] code);
    int unsigned ns;
    ns = (code == FILTER_LONG_CODE) ? FILTER_LONG_NS : (int'(code) + 1) * FILTER_STEP_NS;
    return 6'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : filter_cycles

  fd_control_t fd_r, fd_nxt;
  logic [7:0] trim_low_r, trim_low_nxt;
  logic [4:0] trim_high_r, trim_high_nxt;
  logic rx_sel_r, rx_sel_nxt;
  logic [7:0] cal_high_r, cal_high_nxt;
  logic [7:0] payload_r, payload_nxt;
  logic [7:0] rd_data_r, rd_data_nxt;
  logic [5:0] filt_cyc_r, filt_cyc_nxt;
  logic unlocked;

  assign unlocked = (trim_enable_i == TRIM_UNLOCK_CODE);

  always_comb begin
    fd_nxt = fd_r;
    trim_low_nxt = trim_low_r;
    trim_high_nxt = trim_high_r;
    rx_sel_nxt = rx_sel_r;
    payload_nxt = payload_r;
    cal_high_nxt = calibration_high_i;
    rd_data_nxt = rd_data_r;
    if (req_i.write) begin
      case (req_i.addr)
        ADDR_PAYLOAD_BYTE_ZERO: begin
          payload_nxt = req_i.wdata;
        end
        ADDR_FD_TOLERANT_CONTROL: begin
          fd_nxt.error_counter_disable = req_i.wdata[FD_ERRDIS_BIT];
          fd_nxt.receive_analog_filter_bypass = req_i.wdata[FD_BYPASS_BIT];
          fd_nxt.dominant_filter_time = req_i.wdata[DOMINANT_FILTER_TIME_MSB:DOMINANT_FILTER_TIME_LSB];
          fd_nxt.fd_tolerant_enable = req_i.wdata[FD_ENABLE_BIT];
        end
        ADDR_OSCILLATOR_TRIM_LOW: begin
          if (unlocked) begin
            trim_low_nxt = req_i.wdata;
          end
        end
        ADDR_WAKE_OPTIONS_TRIM_HIGH: begin
          if (unlocked) begin
            trim_high_nxt = req_i.wdata[OPT_TRIM_MSB:OPT_TRIM_LSB];
            rx_sel_nxt = req_i.wdata[OPT_RXSEL_BIT];
          end
        end
        default: begin
        end
      endcase
    end
    // Hardware clear at silence expiry beats a same-cycle software set
    if (silence_timeout_i) begin
      fd_nxt.error_counter_disable = 1'b0;
    end
    if (req_i.read) begin
      case (req_i.addr)
        ADDR_PAYLOAD_BYTE_ZERO: rd_data_nxt = payload_r;
        ADDR_FD_TOLERANT_CONTROL: rd_data_nxt = {2'h0, fd_r};
        ADDR_OSCILLATOR_TRIM_LOW: rd_data_nxt = trim_low_r;
        ADDR_WAKE_OPTIONS_TRIM_HIGH: rd_data_nxt = {rx_sel_r, 2'h0, trim_high_r};
        ADDR_OSCILLATOR_CALIBRATION_HIGH: rd_data_nxt = cal_high_r;
        default: rd_data_nxt = 8'h00;
      endcase
    end
    // Filter time follows the code alone, bypass never touches it
    filt_cyc_nxt = filter_cycles(fd_r.dominant_filter_time);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      fd_r <= fd_control_t'(FD_CONTROL_RESET[5:0]);
      trim_low_r <= TRIM_LOW_RESET;
      trim_high_r <= TRIM_HIGH_RESET;
      rx_sel_r <= WAKE_RX_SELECT_RESET;
      cal_high_r <= CAL_HIGH_RESET;
      payload_r <= PAYLOAD_RESET;
      rd_data_r <= 8'h00;
      filt_cyc_r <= 6'h00;
    end else begin
      fd_r <= fd_nxt;
      trim_low_r <= trim_low_nxt;
      trim_high_r <= trim_high_nxt;
      rx_sel_r <= rx_sel_nxt;
      cal_high_r <= cal_high_nxt;
      payload_r <= payload_nxt;
      rd_data_r <= rd_data_nxt;
      filt_cyc_r <= filt_cyc_nxt;
    end
  end

  assign rd_data_o = rd_data_r;
  assign fd_control_o = fd_r;
  assign error_counter_active_o = !(fd_r.error_counter_disable && fd_r.fd_tolerant_enable);
  assign analog_filter_in_path_o = !fd_r.receive_analog_filter_bypass;
  assign dominant_filter_cycles_o = filt_cyc_r;
  assign trim_word_o = {trim_high_r, trim_low_r};
  assign wake_receiver_select_o = rx_sel_r;
  assign payload_byte_zero_o = payload_r;

endmodule : selective_wake_fd_trim_regs

// ==== sim/swk_regs_monitor.sv ====
`timescale 1ns/1ps
module swk_regs_monitor
  import swk_fd_trim_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire reg_req_t req_i,
  input wire logic [1:0] trim_enable_i,
  input wire logic silence_timeout_i,
  input wire logic [7:0] rd_data_o,
  input wire fd_control_t fd_control_o,
  input wire logic error_counter_active_o,
  input wire logic analog_filter_in_path_o,
  input wire logic [5:0] dominant_filter_cycles_o,
  input wire trim_word_t trim_word_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  sequence locked_wr;
    req_i.write && trim_enable_i != TRIM_UNLOCK_CODE && req_i.addr inside {7'h38, 7'h39};
  endsequence
  sequence ctrl_rd;
    req_i.read && req_i.addr == ADDR_FD_TOLERANT_CONTROL;
  endsequence
  chk_err_active: assert property (
    error_counter_active_o == !(fd_control_o.error_counter_disable && fd_control_o.fd_tolerant_enable))
    else $error("error counter state wrong");
  chk_silence_clear: assert property (silence_timeout_i |=> !fd_control_o.error_counter_disable)
    else $error("disable bit not cleared");
  chk_filter_path: assert property (analog_filter_in_path_o != fd_control_o.receive_analog_filter_bypass)
    else $error("analog filter path wrong");
  chk_long_filter: assert property (fd_control_o.dominant_filter_time == 3'h7 |=> dominant_filter_cycles_o == 6'h27)
    else $error("long filter time wrong");
  chk_short_filter: assert property (fd_control_o.dominant_filter_time == 3'h0 |=> dominant_filter_cycles_o == 6'h03)
    else $error("short filter time wrong");
  chk_ctrl_write: assert property (
    req_i.write && req_i.addr == ADDR_FD_TOLERANT_CONTROL && !silence_timeout_i
    |=> fd_control_o == $past(req_i.wdata[5:0])) else $error("control write lost");
  chk_ctrl_read: assert property (ctrl_rd |=> rd_data_o == {2'h0, $past(fd_control_o)})
    else $error("control read wrong");
  chk_trim_locked: assert property (locked_wr |=> $stable(trim_word_o))
    else $error("locked trim changed");
endmodule : swk_regs_monitor
bind selective_wake_fd_trim_regs swk_regs_monitor i_swk_regs_monitor (.*);

// ==== sim/selective_wake_fd_trim_regs_tb_top.sv ====
`timescale 1ns/1ps
module selective_wake_fd_trim_regs_tb_top
  import swk_fd_trim_pkg::*;
;
  logic sys_clk_i = 0, reset_i = 1, silence_timeout_i = 0, error_counter_active_o, analog_filter_in_path_o;
  logic wake_receiver_select_o;
  reg_req_t req_i = '0;
  logic [1:0] trim_enable_i = 0;
  logic [7:0] calibration_high_i = 8'h5a, rd_data_o, payload_byte_zero_o, d, tl = 0, opt = 0;
  logic [5:0] dominant_filter_cycles_o;
  logic [31:0] seed = 32'haed3;
  fd_control_t fd_control_o;
  trim_word_t trim_word_o;
  int errors = 0, checks_done = 0;
  selective_wake_fd_trim_regs i_selective_wake_fd_trim_regs (.*);
  initial forever #10 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Cycles at 20 ns for a filter code, rounded up
  function automatic logic [5:0] exp_cycles(input logic [2:0] c);
    int ns;
    ns = (c == 3'h7) ? 775 : (int'(c) + 1) * 50;
    return 6'((ns + 19) / 20);
  endfunction : exp_cycles
  task chk(input logic [15:0] seen, exp, input string nm);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request is left up so back-to-back calls never drive it twice per step
  task op(input logic w, r, input logic [6:0] a, input logic [7:0] v);
    req_i = '{w, r, a, v};
    @(posedge sys_clk_i);
    #1;
  endtask : op
  task rd(input logic [6:0] a, input logic [15:0] exp);
    op(0, 1, a, 0);
    chk(rd_data_o, exp, "read");
  endtask : rd
  task final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial begin
    #(20 * 2000);
    errors++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1 reset_i = 0;
    rd(ADDR_FD_TOLERANT_CONTROL, 0);
    op(1, 0, ADDR_OSCILLATOR_CALIBRATION_HIGH, 8'h00);
    rd(ADDR_OSCILLATOR_CALIBRATION_HIGH, 8'h5a);
    // One-off factory style trim load, later writes keep trim low bits 7:5 and all five trim high bits
    trim_enable_i = 2'h3;
    op(1, 0, ADDR_OSCILLATOR_TRIM_LOW, 8'he0);
    op(1, 0, ADDR_WAKE_OPTIONS_TRIM_HIGH, 8'h15);
    {tl, opt} = {8'he0, 8'h15};
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      if (i < 8) d[4:1] = {~i[0], i[2:0]};
      trim_enable_i = seed[9:8] | {2{i[0]}};
      op(1, 0, ADDR_PAYLOAD_BYTE_ZERO, d);
      rd(ADDR_PAYLOAD_BYTE_ZERO, d);
      chk(payload_byte_zero_o, d, "payload");
      op(1, 0, ADDR_FD_TOLERANT_CONTROL, d);
      rd(ADDR_FD_TOLERANT_CONTROL, d & 8'h3f);
      chk(fd_control_o, d[5:0], "fd control");
      chk(analog_filter_in_path_o, !d[4], "filter path");
      chk(dominant_filter_cycles_o, exp_cycles(d[3:1]), "filter cycles");
      op(1, 0, ADDR_OSCILLATOR_TRIM_LOW, {tl[7:5], ~d[4:0]});
      op(1, 0, ADDR_WAKE_OPTIONS_TRIM_HIGH, {d[7:5], opt[4:0]});
      if (trim_enable_i == 2'h3) {tl, opt} = {tl[7:5], ~d[4:0], d[7], 2'h0, opt[4:0]};
      rd(ADDR_OSCILLATOR_TRIM_LOW, tl);
      rd(ADDR_WAKE_OPTIONS_TRIM_HIGH, opt);
      chk(trim_word_o, {opt[4:0], tl}, "trim word");
      chk(wake_receiver_select_o, opt[7], "rx select");
    end
    trim_enable_i = 2'h3;
    op(1, 0, ADDR_WAKE_OPTIONS_TRIM_HIGH, {3'h4, opt[4:0]});
    chk(wake_receiver_select_o, 1, "low power rx");
    chk(trim_word_o, {opt[4:0], tl}, "trim kept");
    op(1, 0, ADDR_FD_TOLERANT_CONTROL, 8'h21);
    chk(error_counter_active_o, 0, "err off");
    silence_timeout_i = 1;
    @(posedge sys_clk_i);
    #1 silence_timeout_i = 0;
    chk(error_counter_active_o, 1, "err active");
    rd(ADDR_FD_TOLERANT_CONTROL, 8'h01);
    rd(7'h40, 0);
    final_report;
  end
endmodule : selective_wake_fd_trim_regs_tb_top
